//--- rtl/fdd_drive.sv
`default_nettype none
`include "fdd_regs.svh"

//
// Contract
// - host waits 700 ms motor spin-up
// - host waits 18 ms after step
// - both waits may overlap
// - ready plus write gate enables write current
// - host selects reduced current from track 43
// - trim erase on 190 us after gate
// - write data edge toggles winding half
// - first data pulse within 4 us
// - host adds one trailing data pulse
// - write busy from gate to erase off
// - read isolated while writing; side picks head
// - host waits 100 us after erase
// - read valid after latest of three waits
// - each read peak gives 200 ns pulse
// - interface lines are active low
// - drive answers one strap-chosen select line
// - deselected drive ignores all inputs but motor on, releases outputs
// - host asserts one select at most
// - host holds select until command done
// - write protect disables writing, reported
// - no stepping while writing
// - ready only when spindle at speed
module fdd_drive
  import fdd_pkg::*;
#(
  parameter int unsigned SPIN_CYC = `FDD_SPIN_CYC,
  parameter int unsigned TRIM_CYC = `FDD_TRIM_CYC,
  parameter int unsigned LAG_CYC  = `FDD_LAG_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [1:0] strap_i,
  input  wire logic       wp_sense_i,
  input  wire logic       track0_sense_i,
  input  wire logic       index_sense_i,
  input  wire logic       peak_i,
  fdd_if.drive            cable,
  output logic            motor_on_o,
  output logic            at_speed_o,
  output logic            wr_current_o,
  output logic            wr_low_current_o,
  output logic            head_phase_o,
  output logic            trim_erase_o,
  output logic            write_busy_o,
  output logic            read_isolate_o,
  output logic            head_side_o,
  output logic            step_o,
  output logic            step_dir_o
);

  fdd_drv_st_t r;
  fdd_drv_st_t n;

  logic [14:0] raw;
  logic [14:0] act;
  logic [14:0] prev;
  logic        sel;
  logic        gate;
  logic        wd_edge;
  logic        spin_start;
  logic        spin_done;
  logic        trim_start;
  logic        trim_done;
  logic        lag_start;
  logic        lag_done;
  logic        rp_start;
  logic        rp_busy;

  // ----------------------------------------------------------------
  // capture: cable inverted to active high, all through two flops
  // ----------------------------------------------------------------
  assign raw = {peak_i, index_sense_i, track0_sense_i, wp_sense_i,
                ~cable.motor_on_n, ~cable.side_n, ~cable.wcur_sw_n, ~cable.wdata_n,
                ~cable.wgate_n, ~cable.dir_n, ~cable.step_n,
                ~cable.select_line_d_n, ~cable.select_line_c_n,
                ~cable.select_line_b_n, ~cable.select_line_a_n};
  assign act  = r.s2;
  assign prev = r.s3;

  // ----------------------------------------------------------------
  // selection and qualified inputs
  // ----------------------------------------------------------------
  assign sel     = r.strap_ok & fdd_sel_hit(act[3:0], r.addr);
  assign gate    = sel & act[`FDD_I_WGATE];
  assign wd_edge = sel & act[`FDD_I_WDATA] & ~prev[`FDD_I_WDATA];

  assign spin_start = act[`FDD_I_MOTOR] & ~prev[`FDD_I_MOTOR];
  // peaks are dropped while the read path is isolated
  assign rp_start   = sel & act[`FDD_I_PEAK] & ~prev[`FDD_I_PEAK] & (r.st == D_IDLE);

  // ----------------------------------------------------------------
  // timers
  // ----------------------------------------------------------------
  fdd_timer u_spin (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (spin_start),
    .len_i   (32'(SPIN_CYC)),
    .busy_o  (),
    .done_o  (spin_done)
  );

  fdd_timer u_trim (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (trim_start),
    .len_i   (32'(TRIM_CYC)),
    .busy_o  (),
    .done_o  (trim_done)
  );

  fdd_timer u_lag (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (lag_start),
    .len_i   (32'(LAG_CYC)),
    .busy_o  (),
    .done_o  (lag_done)
  );

  fdd_timer u_rpulse (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (rp_start),
    .len_i   (32'(`FDD_RPULSE_CYC)),
    .busy_o  (rp_busy),
    .done_o  ()
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    n.s1   = raw;
    n.s2   = r.s1;
    n.s3   = r.s2;
    n.step = 1'b0;
    trim_start = 1'b0;
    lag_start  = 1'b0;

    // strap caught once, after reset release
    if (!r.strap_ok) begin
      n.addr     = strap_i;
      n.strap_ok = 1'b1;
    end

    if (!act[`FDD_I_MOTOR]) begin
      n.at_speed = 1'b0;
    end else if (spin_done) begin
      n.at_speed = 1'b1;
    end

    case (r.st)
      D_IDLE: begin
        if (gate && !prev[`FDD_I_WGATE] && r.at_speed && !act[`FDD_I_WP]) begin
          n.st     = D_WRITE;
          n.wr_cur = 1'b1;
          n.wr_low = act[`FDD_I_WCUR];
          n.busy   = 1'b1;
          n.rd_iso = 1'b1;
          n.side   = act[`FDD_I_SIDE];
          trim_start = 1'b1;
          // gate and first pulse may arrive in one cycle
          if (wd_edge) begin
            n.head_phase = ~r.head_phase;
          end
        end else if (sel) begin
          n.side = act[`FDD_I_SIDE];
        end
        // stepping only outside a write
        if (sel && act[`FDD_I_STEP] && !prev[`FDD_I_STEP]) begin
          n.step     = 1'b1;
          n.step_dir = act[`FDD_I_DIR];
        end
      end
      D_WRITE: begin
        n.wr_low = act[`FDD_I_WCUR];
        if (wd_edge) begin
          n.head_phase = ~r.head_phase;
        end
        if (trim_done) begin
          n.trim = 1'b1;
        end
        // deselect counts as gate false so current never stays on
        if (!gate) begin
          n.st     = D_TAIL;
          n.wr_cur = 1'b0;
          n.wr_low = 1'b0;
          lag_start = 1'b1;
        end
      end
      D_TAIL: begin
        if (lag_done) begin
          n.st     = D_IDLE;
          n.trim   = 1'b0;
          n.busy   = 1'b0;
          n.rd_iso = 1'b0;
        end
      end
      default: begin
        n.st = D_IDLE;
      end
    endcase

    // status lines, released while deselected
    n.oe      = sel;
    n.rdata_n = ~rp_busy;
    n.ready_n = ~r.at_speed;
    n.wprot_n = ~act[`FDD_I_WP];
    n.trk0_n  = ~act[`FDD_I_TRK0];
    n.idx_n   = ~act[`FDD_I_IDX];
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '{st: D_IDLE, oe: 1'b0, rdata_n: 1'b1, ready_n: 1'b1, wprot_n: 1'b1,
             trk0_n: 1'b1, idx_n: 1'b1, default: '0};
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign cable.rdata_drv = r.rdata_n;
  assign cable.ready_drv = r.ready_n;
  assign cable.wprot_drv = r.wprot_n;
  assign cable.trk0_drv  = r.trk0_n;
  assign cable.idx_drv   = r.idx_n;
  assign cable.stat_oe   = r.oe;

  assign motor_on_o       = r.s2[`FDD_I_MOTOR];
  assign at_speed_o       = r.at_speed;
  assign wr_current_o     = r.wr_cur;
  assign wr_low_current_o = r.wr_low;
  assign head_phase_o     = r.head_phase;
  assign trim_erase_o     = r.trim;
  assign write_busy_o     = r.busy;
  assign read_isolate_o   = r.rd_iso;
  assign head_side_o      = r.side;
  assign step_o           = r.step;
  assign step_dir_o       = r.step_dir;

endmodule
`default_nettype wire

//--- rtl/fdd_regs.svh
`ifndef FDD_REGS_SVH
`define FDD_REGS_SVH

// ----------------------------------------------------------------
// clock and times
// ----------------------------------------------------------------
`define FDD_CLK_MHZ        100
`define FDD_SPIN_MS        700
`define FDD_RDSPIN_MS      250
`define FDD_STEP_MS        3
`define FDD_SETTLE_MS      15
`define FDD_RDSTEP_MS      20
`define FDD_TRIM_US        190
`define FDD_ERASE_LAG_US   190
`define FDD_RDREC_US       100
`define FDD_RPULSE_NS      200
`define FDD_WD_PW_NS       100
`define FDD_STEP_PW_NS     1000
`define FDD_REDUCED_TRACK  43

// ----------------------------------------------------------------
// derived cycle counts
// ----------------------------------------------------------------
`define FDD_SPIN_CYC       (`FDD_SPIN_MS * 1000 * `FDD_CLK_MHZ)
`define FDD_RDSPIN_CYC     (`FDD_RDSPIN_MS * 1000 * `FDD_CLK_MHZ)
`define FDD_SEEK_CYC       ((`FDD_STEP_MS + `FDD_SETTLE_MS) * 1000 * `FDD_CLK_MHZ)
`define FDD_RDSTEP_CYC     (`FDD_RDSTEP_MS * 1000 * `FDD_CLK_MHZ)
`define FDD_TRIM_CYC       (`FDD_TRIM_US * `FDD_CLK_MHZ)
`define FDD_LAG_CYC        (`FDD_ERASE_LAG_US * `FDD_CLK_MHZ)
`define FDD_RDREC_CYC      ((`FDD_ERASE_LAG_US + `FDD_RDREC_US) * `FDD_CLK_MHZ)
`define FDD_RPULSE_CYC     (`FDD_RPULSE_NS * `FDD_CLK_MHZ / 1000)
`define FDD_WD_PW_CYC      (`FDD_WD_PW_NS * `FDD_CLK_MHZ / 1000)
`define FDD_STEP_PW_CYC    (`FDD_STEP_PW_NS * `FDD_CLK_MHZ / 1000)

// ----------------------------------------------------------------
// drive input vector positions (active high after capture)
// ----------------------------------------------------------------
`define FDD_I_STEP   4
`define FDD_I_DIR    5
`define FDD_I_WGATE  6
`define FDD_I_WDATA  7
`define FDD_I_WCUR   8
`define FDD_I_SIDE   9
`define FDD_I_MOTOR  10
`define FDD_I_WP     11
`define FDD_I_TRK0   12
`define FDD_I_IDX    13
`define FDD_I_PEAK   14
`define FDD_I_W      15

`endif

//--- rtl/fdd_pkg.sv
`default_nettype none
package fdd_pkg;

  typedef enum logic [1:0] {D_IDLE, D_WRITE, D_TAIL} fdd_dstate_t;
  typedef enum logic [2:0] {H_IDLE, H_STEP, H_ARM, H_WRITE, H_TAIL} fdd_hstate_t;

  typedef struct packed {
    logic [31:0] cnt;
    logic        busy;
    logic        done;
  } fdd_tmr_st_t;

  typedef struct packed {
    logic [14:0] s1;
    logic [14:0] s2;
    logic [14:0] s3;
    logic [1:0]  addr;
    logic        strap_ok;
    fdd_dstate_t st;
    logic        at_speed;
    logic        wr_cur;
    logic        wr_low;
    logic        head_phase;
    logic        trim;
    logic        busy;
    logic        rd_iso;
    logic        side;
    logic        step;
    logic        step_dir;
    logic        oe;
    logic        rdata_n;
    logic        ready_n;
    logic        wprot_n;
    logic        trk0_n;
    logic        idx_n;
  } fdd_drv_st_t;

  typedef struct packed {
    logic [4:0]  s1;
    logic [4:0]  s2;
    logic [4:0]  s3;
    fdd_hstate_t st;
    logic        sel_en;
    logic [1:0]  addr;
    logic        motor;
    logic        step_n;
    logic        dir_n;
    logic        wgate_n;
    logic        wdata_n;
    logic        wcur_n;
    logic        side_n;
    logic [7:0]  pcnt;
  } fdd_host_st_t;

  function automatic logic fdd_sel_hit(input logic [3:0] sel, input logic [1:0] addr);
    return sel[addr];
  endfunction

  function automatic logic [3:0] fdd_sel_onehot(input logic en, input logic [1:0] addr);
    return en ? (4'h1 << addr) : 4'h0;
  endfunction

endpackage
`default_nettype wire

//--- rtl/fdd_if.sv
`default_nettype none
interface fdd_if;
  // host to drive, active low
  logic select_line_a_n;
  logic select_line_b_n;
  logic select_line_c_n;
  logic select_line_d_n;
  logic step_n;
  logic dir_n;
  logic wgate_n;
  logic wdata_n;
  logic wcur_sw_n;
  logic side_n;
  logic motor_on_n;
  // drive to host: open collector value and enable
  logic rdata_drv;
  logic ready_drv;
  logic wprot_drv;
  logic trk0_drv;
  logic idx_drv;
  logic stat_oe;
  // resolved lines, pulled high when released
  logic rdata_n;
  logic ready_n;
  logic wprot_n;
  logic trk0_n;
  logic idx_n;

  assign rdata_n = ~(stat_oe & ~rdata_drv);
  assign ready_n = ~(stat_oe & ~ready_drv);
  assign wprot_n = ~(stat_oe & ~wprot_drv);
  assign trk0_n  = ~(stat_oe & ~trk0_drv);
  assign idx_n   = ~(stat_oe & ~idx_drv);

  modport host (
    output select_line_a_n, select_line_b_n, select_line_c_n, select_line_d_n,
    output step_n, dir_n, wgate_n, wdata_n, wcur_sw_n, side_n, motor_on_n,
    input  rdata_n, ready_n, wprot_n, trk0_n, idx_n
  );

  modport drive (
    input  select_line_a_n, select_line_b_n, select_line_c_n, select_line_d_n,
    input  step_n, dir_n, wgate_n, wdata_n, wcur_sw_n, side_n, motor_on_n,
    output rdata_drv, ready_drv, wprot_drv, trk0_drv, idx_drv, stat_oe
  );
endinterface
`default_nettype wire

//--- rtl/fdd_timer.sv
`default_nettype none
module fdd_timer
  import fdd_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        start_i,
  input  wire logic [31:0] len_i,
  output logic             busy_o,
  output logic             done_o
);

  fdd_tmr_st_t r;
  fdd_tmr_st_t n;

  // ----------------------------------------------------------------
  // countdown, restart wins over a running count
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    n.done = 1'b0;
    if (start_i) begin
      n.cnt  = len_i;
      n.busy = (len_i != 32'h0);
    end else if (r.busy) begin
      n.cnt = r.cnt - 32'h1;
      if (r.cnt == 32'h1) begin
        n.busy = 1'b0;
        n.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign busy_o = r.busy;
  assign done_o = r.done;

endmodule
`default_nettype wire

//--- rtl/fdd_host.sv
`default_nettype none
`include "fdd_regs.svh"

module fdd_host
  import fdd_pkg::*;
#(
  parameter int unsigned SPIN_CYC   = `FDD_SPIN_CYC,
  parameter int unsigned RDSPIN_CYC = `FDD_RDSPIN_CYC,
  parameter int unsigned SEEK_CYC   = `FDD_SEEK_CYC,
  parameter int unsigned RDSTEP_CYC = `FDD_RDSTEP_CYC,
  parameter int unsigned RDREC_CYC  = `FDD_RDREC_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       motor_on_i,
  input  wire logic       sel_en_i,
  input  wire logic [1:0] sel_addr_i,
  input  wire logic       step_i,
  input  wire logic       step_dir_i,
  input  wire logic       write_i,
  input  wire logic       wdata_i,
  input  wire logic       side_i,
  input  wire logic [6:0] track_i,
  fdd_if.host             cable,
  output logic            wr_ready_o,
  output logic            rd_valid_o,
  output logic            busy_o,
  output logic            rd_pulse_o,
  output logic            drv_ready_o,
  output logic            wprot_o,
  output logic            track0_o,
  output logic            index_o
);

  fdd_host_st_t r;
  fdd_host_st_t n;
  logic         spin_start;
  logic         step_start;
  logic         wend;
  logic         spin_busy;
  logic         rdspin_busy;
  logic         seek_busy;
  logic         rdstep_busy;
  logic         rdrec_busy;
  logic         wr_ready;
  logic [3:0]   sel_oh;

  // ----------------------------------------------------------------
  // readiness timers, run side by side
  // ----------------------------------------------------------------
  fdd_timer u_spin (.clk_i(clk_i), .rst_i(rst_i), .start_i(spin_start),
    .len_i(32'(SPIN_CYC)), .busy_o(spin_busy), .done_o());
  fdd_timer u_rdspin (.clk_i(clk_i), .rst_i(rst_i), .start_i(spin_start),
    .len_i(32'(RDSPIN_CYC)), .busy_o(rdspin_busy), .done_o());
  fdd_timer u_seek (.clk_i(clk_i), .rst_i(rst_i), .start_i(step_start),
    .len_i(32'(SEEK_CYC)), .busy_o(seek_busy), .done_o());
  fdd_timer u_rdstep (.clk_i(clk_i), .rst_i(rst_i), .start_i(step_start),
    .len_i(32'(RDSTEP_CYC)), .busy_o(rdstep_busy), .done_o());
  fdd_timer u_rdrec (.clk_i(clk_i), .rst_i(rst_i), .start_i(wend),
    .len_i(32'(RDREC_CYC)), .busy_o(rdrec_busy), .done_o());

  assign spin_start = motor_on_i & ~r.motor;
  // both waits overlap; ready once the later one ends
  assign wr_ready   = r.motor & ~spin_busy & ~seek_busy & r.s2[3];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    n.s1 = ~{cable.rdata_n, cable.ready_n, cable.wprot_n, cable.trk0_n, cable.idx_n};
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.motor = motor_on_i;
    step_start = 1'b0;
    wend       = 1'b0;
    if (r.pcnt != 8'h0) begin
      n.pcnt = r.pcnt - 8'h1;
      if (r.pcnt == 8'h1) begin
        n.step_n  = 1'b1;
        n.wdata_n = 1'b1;
      end
    end
    case (r.st)
      H_IDLE: begin
        n.side_n = ~side_i;
        if (step_i && r.sel_en) begin
          n.st     = H_STEP;
          n.step_n = 1'b0;
          n.dir_n  = ~step_dir_i;
          n.pcnt   = 8'(`FDD_STEP_PW_CYC);
          step_start = 1'b1;
        end else if (write_i && r.sel_en && wr_ready && !r.s2[2]) begin
          n.st     = H_ARM;
          n.wcur_n = ~(track_i >= 7'(`FDD_REDUCED_TRACK));
        end else begin
          // select may change only between commands
          n.sel_en = sel_en_i;
          n.addr   = sel_addr_i;
        end
      end
      H_STEP: begin
        if (r.pcnt == 8'h1) begin
          n.st = H_IDLE;
        end
      end
      H_ARM: begin
        if (!write_i) begin
          n.st = H_IDLE;
        end else if (wdata_i) begin
          // gate raised with the first pulse itself
          n.st      = H_WRITE;
          n.wgate_n = 1'b0;
          n.wdata_n = 1'b0;
          n.pcnt    = 8'(`FDD_WD_PW_CYC);
        end
      end
      H_WRITE: begin
        if (r.pcnt == 8'h0) begin
          if (!write_i) begin
            n.st      = H_TAIL;
            n.wdata_n = 1'b0;
            n.pcnt    = 8'(`FDD_WD_PW_CYC);
          end else if (wdata_i) begin
            n.wdata_n = 1'b0;
            n.pcnt    = 8'(`FDD_WD_PW_CYC);
          end
        end
      end
      H_TAIL: begin
        if (r.pcnt == 8'h0) begin
          n.st      = H_IDLE;
          n.wgate_n = 1'b1;
          n.wcur_n  = 1'b1;
          wend      = 1'b1;
        end
      end
      default: begin
        n.st = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '{st: H_IDLE, step_n: 1'b1, dir_n: 1'b1, wgate_n: 1'b1, wdata_n: 1'b1,
             wcur_n: 1'b1, side_n: 1'b1, default: '0};
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign sel_oh = fdd_sel_onehot(r.sel_en, r.addr);

  assign cable.select_line_a_n = ~sel_oh[0];
  assign cable.select_line_b_n = ~sel_oh[1];
  assign cable.select_line_c_n = ~sel_oh[2];
  assign cable.select_line_d_n = ~sel_oh[3];
  assign cable.step_n          = r.step_n;
  assign cable.dir_n           = r.dir_n;
  assign cable.wgate_n         = r.wgate_n;
  assign cable.wdata_n         = r.wdata_n;
  assign cable.wcur_sw_n       = r.wcur_n;
  assign cable.side_n          = r.side_n;
  assign cable.motor_on_n      = ~r.motor;

  assign wr_ready_o  = wr_ready & (r.st == H_IDLE);
  assign rd_valid_o  = wr_ready & ~rdspin_busy & ~rdstep_busy & ~rdrec_busy & (r.st == H_IDLE);
  assign busy_o      = (r.st != H_IDLE);
  assign rd_pulse_o  = r.s2[4] & ~r.s3[4];
  assign drv_ready_o = r.s2[3];
  assign wprot_o     = r.s2[2];
  assign track0_o    = r.s2[1];
  assign index_o     = r.s2[0];

endmodule
`default_nettype wire

//--- tb/fdd_checker.sv
`default_nettype none
module fdd_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic select_line_a_n,
  input wire logic select_line_b_n,
  input wire logic select_line_c_n,
  input wire logic select_line_d_n,
  input wire logic step_n,
  input wire logic wgate_n,
  input wire logic wdata_n,
  input wire logic rdata_n,
  input wire logic ready_n,
  input wire logic wprot_n,
  input wire logic stat_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] sel_n;
  assign sel_n = {select_line_d_n, select_line_c_n, select_line_b_n, select_line_a_n};
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ----------------------------------------------------------------
  // cable relations
  // ----------------------------------------------------------------
  property p_one_sel;
    $onehot0(~sel_n);
  endproperty
  a_one_sel: assert property (p_one_sel) else $error("two select lines low");
  // one extra cycle of margin over the enable lag
  property p_oe_off;
    (&sel_n) [*5] |-> !stat_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("status driven while deselected");
  property p_release;
    !stat_oe |-> rdata_n && ready_n && wprot_n;
  endproperty
  a_release: assert property (p_release) else $error("released line not high");
  property p_sel_hold;
    (!step_n || !wgate_n) |-> $stable(sel_n);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("select moved during command");
  property p_step_pw;
    $fell(step_n) |-> ##99 !step_n ##1 step_n;
  endproperty
  a_step_pw: assert property (p_step_pw) else $error("step pulse width wrong");
  property p_first_data;
    $fell(wgate_n) |-> ##[0:400] !wdata_n;
  endproperty
  a_first_data: assert property (p_first_data) else $error("first data pulse late");
  property p_data_pw;
    $fell(wdata_n) |-> ##9 !wdata_n ##1 wdata_n;
  endproperty
  a_data_pw: assert property (p_data_pw) else $error("data pulse width wrong");
  property p_tail;
    $rose(wgate_n) |-> !$past(wdata_n, 1) || !$past(wdata_n, 2) || !$past(wdata_n, 3);
  endproperty
  a_tail: assert property (p_tail) else $error("gate ended without tail pulse");
  property p_no_step_wr;
    !wgate_n |-> step_n;
  endproperty
  a_no_step_wr: assert property (p_no_step_wr) else $error("step during write");
  property p_wr_ready;
    $fell(wgate_n) |-> !ready_n && wprot_n;
  endproperty
  a_wr_ready: assert property (p_wr_ready) else $error("write begun when not allowed");
  property p_rd_pw;
    $fell(rdata_n) |-> ##19 !rdata_n ##1 rdata_n;
  endproperty
  a_rd_pw: assert property (p_rd_pw) else $error("read pulse width wrong");
endmodule
`default_nettype wire

//--- tb/test_flexible_disk_drive_rw_interface.sv
`default_nettype none
module test_flexible_disk_drive_rw_interface;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [1:0] STRAP = 2'h2;
  // shortened timebases so the run stays short
  localparam int unsigned SPIN = 200, TRIM = 80, LAG = 40, RDSP = 100, SEEK = 150, RDST = 160, REC = 150;
  typedef struct packed {
    logic [1:0] addr;
    logic       dir;
    logic       trk;
    logic [7:0] nstep;
    logic       trk0;
  } fdd_row_t;
  localparam fdd_row_t ROWS [5] = '{
    '{2'h2, 1'h1, 1'h1, 8'h1, 1'h1},
    '{2'h0, 1'h0, 1'h1, 8'h0, 1'h0},
    '{2'h1, 1'h1, 1'h0, 8'h0, 1'h0},
    '{2'h3, 1'h1, 1'h1, 8'h0, 1'h0},
    '{2'h2, 1'h0, 1'h0, 8'h1, 1'h0}
  };
  logic clk_i = 1'b0, rst_i = 1'b1, motor_on_i = 1'b0, sel_en_i = 1'b1, step_i = 1'b0, step_dir_i = 1'b0;
  logic write_i = 1'b0, wdata_i = 1'b0, side_i = 1'b0, wp_i = 1'b0, trk0_i = 1'b0, peak_i = 1'b0, idx_i = 1'b0;
  logic [1:0] sel_addr_i = STRAP;
  logic [6:0] track_i = 7'h0;
  logic wr_ready_o, rd_valid_o, busy_o, rd_pulse_o, drv_ready_o, wprot_o, track0_o, index_o;
  logic motor_on_o, at_speed_o, wr_current_o, wr_low_current_o, head_phase_o, trim_erase_o;
  logic write_busy_o, read_isolate_o, head_side_o, step_o, step_dir_o, last_dir;
  int err_total = 0, n_compared = 0, n_step = 0, n_rd = 0;
  fdd_if bus ();
  fdd_drive #(.SPIN_CYC(SPIN), .TRIM_CYC(TRIM), .LAG_CYC(LAG)) i_fdd_drive (
    .clk_i(clk_i), .rst_i(rst_i), .strap_i(STRAP), .wp_sense_i(wp_i), .track0_sense_i(trk0_i),
    .index_sense_i(idx_i), .peak_i(peak_i), .cable(bus), .motor_on_o(motor_on_o), .at_speed_o(at_speed_o),
    .wr_current_o(wr_current_o), .wr_low_current_o(wr_low_current_o), .head_phase_o(head_phase_o),
    .trim_erase_o(trim_erase_o), .write_busy_o(write_busy_o), .read_isolate_o(read_isolate_o),
    .head_side_o(head_side_o), .step_o(step_o), .step_dir_o(step_dir_o));
  fdd_host #(.SPIN_CYC(SPIN), .RDSPIN_CYC(RDSP), .SEEK_CYC(SEEK), .RDSTEP_CYC(RDST), .RDREC_CYC(REC)) i_fdd_host (
    .clk_i(clk_i), .rst_i(rst_i), .motor_on_i(motor_on_i), .sel_en_i(sel_en_i), .sel_addr_i(sel_addr_i),
    .step_i(step_i), .step_dir_i(step_dir_i), .write_i(write_i), .wdata_i(wdata_i), .side_i(side_i),
    .track_i(track_i), .cable(bus), .wr_ready_o(wr_ready_o), .rd_valid_o(rd_valid_o), .busy_o(busy_o),
    .rd_pulse_o(rd_pulse_o), .drv_ready_o(drv_ready_o), .wprot_o(wprot_o), .track0_o(track0_o),
    .index_o(index_o));
  fdd_checker i_chk (
    .clk_i(clk_i), .rst_i(rst_i), .select_line_a_n(bus.select_line_a_n), .select_line_b_n(bus.select_line_b_n),
    .select_line_c_n(bus.select_line_c_n), .select_line_d_n(bus.select_line_d_n), .step_n(bus.step_n),
    .wgate_n(bus.wgate_n), .wdata_n(bus.wdata_n), .rdata_n(bus.rdata_n), .ready_n(bus.ready_n),
    .wprot_n(bus.wprot_n), .stat_oe(bus.stat_oe));
  always #5 clk_i = ~clk_i;
  // counted at the falling edge, clear of the update race
  always @(negedge clk_i) begin
    if (step_o === 1'b1) begin
      n_step++;
      last_dir = step_dir_o;
    end
    if (rd_pulse_o === 1'b1) n_rd++;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic close_out();
    if (err_total == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic peak(input int expn);
    int n0;
    n0 = n_rd;
    @(posedge clk_i) peak_i <= 1'b1;
    cyc(3);
    peak_i <= 1'b0;
    cyc(30);
    chk(8'(n_rd - n0), 8'(expn));
  endtask
  initial begin
    #200000;
    err_total++;
    close_out();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int k, n0;
    logic ph0;
    cyc(6);
    rst_i <= 1'b0;
    motor_on_i <= 1'b1;
    cyc(180);
    chk(8'(at_speed_o), 8'h0);
    chk(8'(wr_ready_o), 8'h0);
    for (k = 0; k < 100 && at_speed_o !== 1'b1; k++) cyc(1);
    cyc(8);
    chk(8'({motor_on_o, drv_ready_o}), 8'h3);
    foreach (ROWS[i]) begin
      @(posedge clk_i) sel_addr_i <= ROWS[i].addr;
      step_dir_i <= ROWS[i].dir;
      trk0_i <= ROWS[i].trk;
      cyc(8);
      n0 = n_step;
      @(posedge clk_i) step_i <= 1'b1;
      @(posedge clk_i) step_i <= 1'b0;
      cyc(110);
      chk(8'(n_step - n0), ROWS[i].nstep);
      chk(8'(track0_o), 8'(ROWS[i].trk0));
      if (ROWS[i].nstep != 8'h0) chk(8'(last_dir), 8'(ROWS[i].dir));
    end
    chk(8'(rd_valid_o), 8'h0);
    for (k = 0; k < 400 && wr_ready_o !== 1'b1; k++) cyc(1);
    ph0 = head_phase_o;
    n0 = n_step;
    @(posedge clk_i) track_i <= 7'd43;
    side_i <= 1'b1;
    write_i <= 1'b1;
    cyc(2);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_i) wdata_i <= 1'b1;
      @(posedge clk_i) wdata_i <= 1'b0;
      step_i <= 1'b1;
      @(posedge clk_i) step_i <= 1'b0;
      cyc(17);
    end
    chk(8'(trim_erase_o), 8'h0);
    chk(8'({wr_current_o, write_busy_o, read_isolate_o, head_side_o, wr_low_current_o}), 8'h1F);
    chk(8'(head_phase_o ^ ph0), 8'h1);
    cyc(40);
    chk(8'(trim_erase_o), 8'h1);
    write_i <= 1'b0;
    for (k = 0; k < 100 && busy_o !== 1'b0; k++) cyc(1);
    cyc(5);
    chk(8'({wr_current_o, write_busy_o, trim_erase_o}), 8'h3);
    chk(8'(head_phase_o ^ ph0), 8'h0);
    chk(8'(n_step - n0), 8'h0);
    chk(8'(rd_valid_o), 8'h0);
    cyc(50);
    chk(8'({write_busy_o, trim_erase_o, read_isolate_o}), 8'h0);
    cyc(160);
    chk(8'(rd_valid_o), 8'h1);
    peak(1);
    @(posedge clk_i) sel_en_i <= 1'b0;
    cyc(8);
    chk(8'(drv_ready_o), 8'h0);
    peak(0);
    @(posedge clk_i) sel_en_i <= 1'b1;
    wp_i <= 1'b1;
    idx_i <= 1'b1;
    cyc(10);
    chk(8'(wprot_o), 8'h1);
    chk(8'(index_o), 8'h1);
    write_i <= 1'b1;
    @(posedge clk_i) wdata_i <= 1'b1;
    @(posedge clk_i) wdata_i <= 1'b0;
    cyc(12);
    chk(8'(wr_current_o), 8'h0);
    write_i <= 1'b0;
    wp_i <= 1'b0;
    cyc(20);
    rst_i <= 1'b1;
    cyc(2);
    chk(8'({at_speed_o, bus.stat_oe, bus.ready_n}), 8'h1);
    rst_i <= 1'b0;
    cyc(3);
    close_out();
  end
endmodule
`default_nettype wire
